// [lnmw_regs.svh]
// constants of the bus transceiver mode, wake and fault block
`ifndef LNMW_REGS_SVH
`define LNMW_REGS_SVH
// ----------------------------------------
// clock and time base
// ----------------------------------------
`define LNMW_REF_NS 20
`define LNMW_US_NS 1000
`define LNMW_TICK_DIV (`LNMW_US_NS / `LNMW_REF_NS)
// ----------------------------------------
// durations in microseconds
// ----------------------------------------
`define LNMW_WAKE_FILT_MIN_US 30
`define LNMW_WAKE_FILT_MAX_US 150
`define LNMW_TXD_TO_US 10000
`define LNMW_BUS_TO_US 10000
`define LNMW_EN_TIME_US 10
// ----------------------------------------
// channel mode field codes
// ----------------------------------------
`define LNMW_CM_OFF 2'h0
`define LNMW_CM_WAKE 2'h1
`define LNMW_CM_RXONLY 2'h2
`define LNMW_CM_NORMAL 2'h3
// ----------------------------------------
// system mode codes
// ----------------------------------------
`define LNMW_SM_NORMAL 3'h0
`define LNMW_SM_STOP 3'h1
`define LNMW_SM_SLEEP 3'h2
`define LNMW_SM_RESTART 3'h3
`define LNMW_SM_FAILSAFE 3'h4
// ----------------------------------------
// wake event word: channel bit above system mode
// ----------------------------------------
`define LNMW_EVW 4
`endif

// [lnmw_pkg.sv]
// types of the bus transceiver mode, wake and fault block
`default_nettype none
package lnmw_pkg;
   typedef enum logic [1:0] {W_IDLE, W_REC, W_DOM, W_LONG} lnmw_wst_t;
   typedef struct packed {
      logic [1:0] mode_prev;
      logic [15:0] en_cnt;
      logic en_done;
      logic tx_ok;
      logic [15:0] txd_cnt;
      logic tx_to;
      logic [15:0] bus_cnt;
      logic clamp;
      lnmw_wst_t wst;
      logic [15:0] wcnt;
      logic armed;
      logic hold;
      logic pend;
      logic [2:0] wsys;
      logic fault;
      logic drv_oe;
      logic rxd;
   } lnmw_ch_t;
endpackage
`default_nettype wire

// [lnmw_strm_if.sv]
// valid/ready stream carrier between the block's modules
`default_nettype none
interface lnmw_strm_if #(parameter int W = 4);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// [lnmw_buf2.sv]
// two-entry buffer for wake event words
`include "lnmw_regs.svh"
`default_nettype none
module lnmw_buf2 (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // streams
   lnmw_strm_if.snk in_s,
   lnmw_strm_if.src out_s
);
   logic v0_q, v1_q, v0_d, v1_d, rdy_q;
   logic [`LNMW_EVW-1:0] d0_q, d1_q, d0_d, d1_d;
   logic push, pop;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      push = in_s.valid && rdy_q;
      pop = v0_q && out_s.ready;
      v0_d = v0_q;
      v1_d = v1_q;
      d0_d = d0_q;
      d1_d = d1_q;
      if (pop) begin
         v0_d = v1_q;
         d0_d = d1_q;
         v1_d = 1'b0;
      end
      if (push) begin
         if (!v0_d) begin
            v0_d = 1'b1;
            d0_d = in_s.data;
         end else begin
            v1_d = 1'b1;
            d1_d = in_s.data;
         end
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         v0_q <= 1'b0;
         v1_q <= 1'b0;
         d0_q <= '0;
         d1_q <= '0;
         rdy_q <= 1'b0;
      end else begin
         v0_q <= v0_d;
         v1_q <= v1_d;
         d0_q <= d0_d;
         d1_q <= d1_d;
         // ready is a flop; a full second slot refuses until it drains
         rdy_q <= !v1_d;
      end
   end

   assign in_s.ready = rdy_q;
   assign out_s.valid = v0_q;
   assign out_s.data = d0_q;
endmodule
`default_nettype wire

// [lnmw_top.sv]
// mode, wake and fault control of two single-wire bus transceiver channels
// ----------------------------------------
// Operation
// - channel starts off after power-up; off ignores any bus wake
// - normal mode runs only in system Normal or Stop mode
// - normal mode drives transmit input onto bus, receive output follows bus
// - dominant present before enabling ends is not sent; only a fresh one
// - receive-only mode disables the driver, reception continues
// - wake-capable selectable in most modes, forced in system Fail-Safe
// - wake needs falling edge, dominant longer than filter, then rising edge
// - wake filter time lies between 30 and 150 microseconds
// - after wake receive output held low until mode changes
// - mode field keeps reading wake-capable after wake; wake disarmed
// - leaving and re-entering wake-capable mode rearms wake
// - system entering Stop, Sleep or Fail-Safe rearms wake
// - wake in Normal or Stop: interrupt low, source recorded, receive low
// - wake in Stop enables disabled watchdog when its option bit set
// - wake in Sleep requests Restart with regulator ramp, no interrupt
// - wake in Restart stays; in Fail-Safe requests Restart with ramp
// - transmit dominant past timeout disables driver and sets fault flag
// - driver returns once transmit input is recessive; mode unchanged
// - bus dominant past timeout in normal or receive-only sets fault
// - bus supply undervoltage disables driver and receiver, mode kept
// - normal slope by default; low slope changes only slew rate
// - low-slope bit accepted in system Normal, applied at chip select rise
// ----------------------------------------
`include "lnmw_regs.svh"
`default_nettype none
module lnmw_top import lnmw_pkg::*; #(
   parameter logic [15:0] WAKE_FILT_US = 16'(`LNMW_WAKE_FILT_MIN_US),
   parameter logic [15:0] TXD_TO_US = 16'(`LNMW_TXD_TO_US),
   parameter logic [15:0] BUS_TO_US = 16'(`LNMW_BUS_TO_US),
   parameter logic [15:0] EN_TIME_US = 16'(`LNMW_EN_TIME_US)
) (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST_B,
   // system and configuration
   input wire logic [2:0] SYS_MODE,
   input wire logic [1:0] FIRST_CHANNEL_MODE_BITS,
   input wire logic [1:0] SECOND_CHANNEL_MODE_BITS,
   input wire logic WATCHDOG_ON_BUS_WAKE,
   input wire logic WATCHDOG_ENABLED,
   input wire logic LOW_SLOPE_SELECT_WR,
   input wire logic SPI_CS_B,
   input wire logic BUS_SUPPLY_UV,
   input wire logic [1:0] FAULT_CLR,
   input wire logic INT_ACK,
   // host pins
   input wire logic [1:0] TRANSMIT_INPUT,
   output logic [1:0] RECEIVE_OUTPUT_PIN,
   // bus pins, open drain
   input wire logic [1:0] BUS_I,
   output logic [1:0] BUS_O,
   output logic [1:0] BUS_OE,
   // status and requests
   output logic [3:0] CH_MODE_RB,
   output logic FIRST_CHANNEL_FAULT_FLAG,
   output logic SECOND_CHANNEL_FAULT_FLAG,
   output logic LOW_SLOPE,
   output logic INT_B,
   output logic WD_AUTO_EN,
   output logic RESTART_REQ,
   // wake source stream
   output logic WAKE_SRC_VALID,
   output logic [`LNMW_EVW-1:0] WAKE_SRC,
   input wire logic WAKE_SRC_READY
);
   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   logic [5:0] pin_s1_q, pin_s2_q;
   logic [1:0] txd_s2_q, bus_s2_q;
   logic uv_s2_q, cs_s2_q;

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         pin_s1_q <= 6'h3d;
         pin_s2_q <= 6'h3d;
      end else begin
         pin_s1_q <= {TRANSMIT_INPUT, BUS_I, BUS_SUPPLY_UV, SPI_CS_B};
         pin_s2_q <= pin_s1_q;
      end
   end

   assign {txd_s2_q, bus_s2_q, uv_s2_q, cs_s2_q} = pin_s2_q;

   // ----------------------------------------
   // system mode helpers
   // ----------------------------------------
   function automatic logic sys_run(input logic [2:0] m);
      sys_run = (m == `LNMW_SM_NORMAL) || (m == `LNMW_SM_STOP);
   endfunction

   function automatic logic sys_rearm(input logic [2:0] m);
      sys_rearm = (m == `LNMW_SM_STOP) || (m == `LNMW_SM_SLEEP) || (m == `LNMW_SM_FAILSAFE);
   endfunction

   // ----------------------------------------
   // global state
   // ----------------------------------------
   logic [5:0] div_q, div_d;
   logic tick_q, tick_d;
   logic [2:0] sys_prev_q, sys_prev_d;
   logic cs_prev_q, cs_prev_d;
   logic lsm_q, lsm_d;
   logic int_b_q, int_b_d;
   logic wd_q, wd_d;
   logic rst_req_q, rst_req_d;
   logic [1:0] wake_ev, pop;
   logic [2:0] ev_sys [2];
   logic enter_rearm;
   logic [1:0] ch_mode_in [2];
   lnmw_ch_t ch_q [2];
   lnmw_ch_t ch_d [2];

   lnmw_strm_if #(.W(`LNMW_EVW)) ev_in ();
   lnmw_strm_if #(.W(`LNMW_EVW)) ev_out ();

   assign ch_mode_in[0] = FIRST_CHANNEL_MODE_BITS;
   assign ch_mode_in[1] = SECOND_CHANNEL_MODE_BITS;
   assign enter_rearm = (SYS_MODE != sys_prev_q) && sys_rearm(SYS_MODE);

   always_comb begin
      div_d = div_q + 6'h01;
      tick_d = 1'b0;
      if (div_q == 6'(`LNMW_TICK_DIV - 1)) begin
         div_d = 6'h00;
         tick_d = 1'b1;
      end
      sys_prev_d = SYS_MODE;
      cs_prev_d = cs_s2_q;
      lsm_d = lsm_q;
      // slope bit is latched from the write only when chip select ends it
      if (cs_s2_q && !cs_prev_q && (SYS_MODE == `LNMW_SM_NORMAL)) begin
         lsm_d = LOW_SLOPE_SELECT_WR;
      end
      int_b_d = int_b_q;
      if (INT_ACK) begin
         int_b_d = 1'b1;
      end
      wd_d = 1'b0;
      rst_req_d = 1'b0;
      for (int k = 0; k < 2; k++) begin
         if (wake_ev[k]) begin
            if (sys_run(ev_sys[k])) begin
               int_b_d = 1'b0;
            end
            if ((ev_sys[k] == `LNMW_SM_STOP) && WATCHDOG_ON_BUS_WAKE && !WATCHDOG_ENABLED) begin
               wd_d = 1'b1;
            end
            if ((ev_sys[k] == `LNMW_SM_SLEEP) || (ev_sys[k] == `LNMW_SM_FAILSAFE)) begin
               rst_req_d = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         div_q <= 6'h00;
         tick_q <= 1'b0;
         sys_prev_q <= `LNMW_SM_NORMAL;
         cs_prev_q <= 1'b1;
         lsm_q <= 1'b0;
         int_b_q <= 1'b1;
         wd_q <= 1'b0;
         rst_req_q <= 1'b0;
      end else begin
         div_q <= div_d;
         tick_q <= tick_d;
         sys_prev_q <= sys_prev_d;
         cs_prev_q <= cs_prev_d;
         lsm_q <= lsm_d;
         int_b_q <= int_b_d;
         wd_q <= wd_d;
         rst_req_q <= rst_req_d;
      end
   end

   // ----------------------------------------
   // wake source hand-off, channel 0 first
   // ----------------------------------------
   assign ev_in.valid = ch_q[0].pend || ch_q[1].pend;
   assign ev_in.data = ch_q[0].pend ? {1'b0, ch_q[0].wsys} : {1'b1, ch_q[1].wsys};
   assign pop[0] = ev_in.ready && ch_q[0].pend;
   assign pop[1] = ev_in.ready && !ch_q[0].pend && ch_q[1].pend;
   assign ev_out.ready = WAKE_SRC_READY;

   lnmw_buf2 u_buf (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .in_s(ev_in),
      .out_s(ev_out)
   );

   // ----------------------------------------
   // per channel logic
   // ----------------------------------------
   for (genvar i = 0; i < 2; i++) begin : g_ch
      logic [1:0] eff;
      logic txd, bus, is_norm, is_rx, wake_on, chg;

      always_comb begin
         // fail-safe forces wake-capable whatever the field holds
         eff = (SYS_MODE == `LNMW_SM_FAILSAFE) ? `LNMW_CM_WAKE : ch_mode_in[i];
         txd = txd_s2_q[i];
         bus = bus_s2_q[i];
         chg = eff != ch_q[i].mode_prev;
         is_norm = (eff == `LNMW_CM_NORMAL) && sys_run(SYS_MODE);
         is_rx = ((eff == `LNMW_CM_NORMAL) || (eff == `LNMW_CM_RXONLY)) && sys_run(SYS_MODE);
         wake_on = (eff == `LNMW_CM_WAKE) && ch_q[i].armed && !uv_s2_q;
         ch_d[i] = ch_q[i];
         ch_d[i].mode_prev = eff;
         wake_ev[i] = 1'b0;
         ev_sys[i] = SYS_MODE;
         // enabling time, then a recessive level must be seen first
         if (!is_norm) begin
            ch_d[i].en_cnt = 16'h0000;
            ch_d[i].en_done = 1'b0;
            ch_d[i].tx_ok = 1'b0;
         end else if (tick_q && !ch_q[i].en_done) begin
            ch_d[i].en_cnt = ch_q[i].en_cnt + 16'h0001;
            ch_d[i].en_done = ch_d[i].en_cnt >= EN_TIME_US;
         end
         if (ch_q[i].en_done && txd) begin
            ch_d[i].tx_ok = 1'b1;
         end
         // transmit dominant timeout
         if (txd) begin
            ch_d[i].txd_cnt = 16'h0000;
            ch_d[i].tx_to = 1'b0;
         end else if (tick_q && !ch_q[i].tx_to) begin
            ch_d[i].txd_cnt = ch_q[i].txd_cnt + 16'h0001;
            ch_d[i].tx_to = ch_q[i].txd_cnt >= TXD_TO_US;
         end
         // bus dominant clamping
         if (bus || !is_rx) begin
            ch_d[i].bus_cnt = 16'h0000;
            ch_d[i].clamp = 1'b0;
         end else if (tick_q && !ch_q[i].clamp) begin
            ch_d[i].bus_cnt = ch_q[i].bus_cnt + 16'h0001;
            ch_d[i].clamp = ch_q[i].bus_cnt >= BUS_TO_US;
         end
         // wake detection: recessive, long dominant, release
         case (ch_q[i].wst)
            W_IDLE: begin
               if (bus) begin
                  ch_d[i].wst = W_REC;
               end
            end
            W_REC: begin
               if (!bus) begin
                  ch_d[i].wst = W_DOM;
                  ch_d[i].wcnt = 16'h0000;
               end
            end
            W_DOM: begin
               if (bus) begin
                  ch_d[i].wst = W_REC;
               end else if (tick_q) begin
                  ch_d[i].wcnt = ch_q[i].wcnt + 16'h0001;
                  if (ch_q[i].wcnt >= WAKE_FILT_US) begin
                     ch_d[i].wst = W_LONG;
                  end
               end
            end
            W_LONG: begin
               if (bus) begin
                  ch_d[i].wst = W_IDLE;
                  wake_ev[i] = 1'b1;
               end
            end
            default: begin
               ch_d[i].wst = W_IDLE;
            end
         endcase
         if (!wake_on) begin
            ch_d[i].wst = W_IDLE;
            wake_ev[i] = 1'b0;
         end
         if (wake_ev[i]) begin
            ch_d[i].armed = 1'b0;
            ch_d[i].hold = 1'b1;
            ch_d[i].wsys = SYS_MODE;
         end
         // rearm on a mode toggle or on entering a low-power system mode
         if (chg && (eff != `LNMW_CM_WAKE)) begin
            ch_d[i].armed = 1'b1;
            ch_d[i].hold = 1'b0;
         end
         if (enter_rearm) begin
            ch_d[i].armed = 1'b1;
         end
         // event pending for the buffer; a new wake wins over the pop
         ch_d[i].pend = wake_ev[i] || (ch_q[i].pend && !pop[i]);
         // fault flag: set wins over software clear
         ch_d[i].fault = (ch_q[i].fault && !FAULT_CLR[i]) || (ch_d[i].tx_to && !ch_q[i].tx_to && is_norm) ||
            (ch_d[i].clamp && !ch_q[i].clamp);
         ch_d[i].drv_oe = is_norm && !uv_s2_q && ch_d[i].tx_ok && !ch_d[i].tx_to && !txd;
         if (ch_d[i].hold) begin
            ch_d[i].rxd = 1'b0;
         end else if (is_rx && !uv_s2_q) begin
            ch_d[i].rxd = bus;
         end else begin
            ch_d[i].rxd = 1'b1;
         end
      end

      always_ff @(posedge REF_CLK or negedge RST_B) begin
         if (!RST_B) begin
            ch_q[i] <= '{mode_prev: `LNMW_CM_OFF, wst: W_IDLE, armed: 1'b1, rxd: 1'b1, default: '0};
         end else begin
            ch_q[i] <= ch_d[i];
         end
      end

      assign RECEIVE_OUTPUT_PIN[i] = ch_q[i].rxd;
      assign BUS_OE[i] = ch_q[i].drv_oe;
      assign BUS_O[i] = 1'b0;
      assign CH_MODE_RB[2*i+1:2*i] = ch_q[i].mode_prev;
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign FIRST_CHANNEL_FAULT_FLAG = ch_q[0].fault;
   assign SECOND_CHANNEL_FAULT_FLAG = ch_q[1].fault;
   // slope only steers the analog slew control; logic timing is unchanged
   assign LOW_SLOPE = lsm_q;
   assign INT_B = int_b_q;
   assign WD_AUTO_EN = wd_q;
   assign RESTART_REQ = rst_req_q;
   assign WAKE_SRC_VALID = ev_out.valid;
   assign WAKE_SRC = ev_out.data;
endmodule
`default_nettype wire

// [lnmw_bus_node.sv]
// other nodes on the two single-wire buses
`default_nettype none
module lnmw_bus_node (
   // block's driver
   input wire logic [1:0] bus_oe,
   // other nodes pulling dominant
   input wire logic [1:0] node_dom,
   // bus level seen by the block
   output logic [1:0] bus_i
);
   // wired-and with a pull-up: a released bus reads recessive, never the last value
   assign bus_i = ~(bus_oe | node_dom);
endmodule
`default_nettype wire

// [lnmw_checker.sv]
// concurrent checks on the ports of the transceiver mode and wake block
`include "lnmw_regs.svh"
`default_nettype none
module lnmw_checker (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST_B,
   // inputs
   input wire logic [2:0] SYS_MODE,
   input wire logic WATCHDOG_ON_BUS_WAKE,
   input wire logic WATCHDOG_ENABLED,
   input wire logic SPI_CS_B,
   input wire logic BUS_SUPPLY_UV,
   input wire logic [1:0] FAULT_CLR,
   input wire logic INT_ACK,
   input wire logic [1:0] TRANSMIT_INPUT,
   input wire logic WAKE_SRC_READY,
   // outputs
   input wire logic [1:0] RECEIVE_OUTPUT_PIN,
   input wire logic [1:0] BUS_OE,
   input wire logic [3:0] CH_MODE_RB,
   input wire logic FIRST_CHANNEL_FAULT_FLAG,
   input wire logic LOW_SLOPE,
   input wire logic INT_B,
   input wire logic WD_AUTO_EN,
   input wire logic RESTART_REQ,
   input wire logic WAKE_SRC_VALID,
   input wire logic [`LNMW_EVW-1:0] WAKE_SRC
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_B);
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_drive_needs_txd: assert property (BUS_OE[0] |-> !$past(TRANSMIT_INPUT[0], 3))
      else $error("bus driven without dominant transmit input");
   a_rxonly_no_drive: assert property ((CH_MODE_RB[3:2] != `LNMW_CM_NORMAL)[*3] |-> !BUS_OE[1])
      else $error("bus driven outside normal mode");
   a_uv_no_drive: assert property (BUS_SUPPLY_UV[*5] |-> BUS_OE == 2'h0)
      else $error("bus driven during undervoltage");
   a_fault_sticky: assert property (FIRST_CHANNEL_FAULT_FLAG && !FAULT_CLR[0] |=> FIRST_CHANNEL_FAULT_FLAG)
      else $error("fault flag dropped without clear");
   a_slope_cause: assert property (!$stable(LOW_SLOPE) |->
      $past(SPI_CS_B, 3) && !$past(SPI_CS_B, 4) && $past(SYS_MODE) == `LNMW_SM_NORMAL)
      else $error("slope changed without accepted chip select rise");
   a_int_hold: assert property (!INT_B && !INT_ACK |=> !INT_B)
      else $error("interrupt released without acknowledge");
   a_int_cause: assert property ($fell(INT_B) |-> RECEIVE_OUTPUT_PIN != 2'h3 &&
      ($past(SYS_MODE) == `LNMW_SM_NORMAL || $past(SYS_MODE) == `LNMW_SM_STOP))
      else $error("interrupt without wake in normal or stop");
   a_restart_cause: assert property (RESTART_REQ |-> !$fell(INT_B) && RECEIVE_OUTPUT_PIN != 2'h3 &&
      ($past(SYS_MODE) == `LNMW_SM_SLEEP || $past(SYS_MODE) == `LNMW_SM_FAILSAFE) ##1 !RESTART_REQ)
      else $error("restart request out of place");
   a_wd_cause: assert property (WD_AUTO_EN |-> $past(SYS_MODE) == `LNMW_SM_STOP && $past(WATCHDOG_ON_BUS_WAKE) &&
      !$past(WATCHDOG_ENABLED) ##1 !WD_AUTO_EN)
      else $error("watchdog enable out of place");
   a_failsafe_wake: assert property ((SYS_MODE == `LNMW_SM_FAILSAFE)[*2] |-> CH_MODE_RB == 4'h5)
      else $error("fail-safe did not force wake-capable");
   a_record_hold: assert property (WAKE_SRC_VALID && !WAKE_SRC_READY |=> WAKE_SRC_VALID && $stable(WAKE_SRC))
      else $error("wake record lost while stalled");
   // ----------------------------------------
   // covers
   // ----------------------------------------
   c_int: cover property ($fell(INT_B));
   c_restart: cover property (RESTART_REQ);
   c_wd: cover property (WD_AUTO_EN);
   c_fault: cover property ($rose(FIRST_CHANNEL_FAULT_FLAG));
endmodule
bind lnmw_top lnmw_checker u_chk (.REF_CLK(REF_CLK), .RST_B(RST_B), .SYS_MODE(SYS_MODE),
   .WATCHDOG_ON_BUS_WAKE(WATCHDOG_ON_BUS_WAKE), .WATCHDOG_ENABLED(WATCHDOG_ENABLED), .SPI_CS_B(SPI_CS_B),
   .BUS_SUPPLY_UV(BUS_SUPPLY_UV), .FAULT_CLR(FAULT_CLR), .INT_ACK(INT_ACK), .TRANSMIT_INPUT(TRANSMIT_INPUT),
   .WAKE_SRC_READY(WAKE_SRC_READY), .RECEIVE_OUTPUT_PIN(RECEIVE_OUTPUT_PIN), .BUS_OE(BUS_OE),
   .CH_MODE_RB(CH_MODE_RB), .FIRST_CHANNEL_FAULT_FLAG(FIRST_CHANNEL_FAULT_FLAG), .LOW_SLOPE(LOW_SLOPE),
   .INT_B(INT_B), .WD_AUTO_EN(WD_AUTO_EN), .RESTART_REQ(RESTART_REQ), .WAKE_SRC_VALID(WAKE_SRC_VALID),
   .WAKE_SRC(WAKE_SRC));
`default_nettype wire

// [testbench.sv]
// self-checking bench for the transceiver mode, wake and fault block
`include "lnmw_regs.svh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   localparam int US = `LNMW_TICK_DIV;
   typedef struct packed {logic [2:0] sm; logic [1:0] m0; logic [1:0] m1; logic [1:0] txd;
      logic [3:0] rb; logic [1:0] oe; logic [1:0] rx;} lnmw_row_t;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [2:0] sm = `LNMW_SM_NORMAL;
   logic [1:0] m0 = 2'h0;
   logic [1:0] m1 = 2'h0;
   logic wd_opt = 1'b0;
   logic wd_on = 1'b0;
   logic lsw = 1'b0;
   logic cs_b = 1'b1;
   logic uv = 1'b0;
   logic [1:0] fclr = 2'h0;
   logic ack = 1'b0;
   logic [1:0] txd = 2'h3;
   logic [1:0] node_dom = 2'h0;
   logic rdy = 1'b0;
   logic [1:0] rx, bus_i, bus_o, oe;
   logic [3:0] rb, src;
   logic f0, f1, slope, int_b, wd_en, rst_req, vld;
   int bad_count = 0;
   int check_count = 0;
   int cycles = 0;
   int restart_n = 0;
   int wd_n = 0;
   lnmw_row_t rows [5] = '{
      '{`LNMW_SM_NORMAL, `LNMW_CM_NORMAL, `LNMW_CM_RXONLY, 2'h0, 4'hb, 2'h1, 2'h2},
      '{`LNMW_SM_STOP, `LNMW_CM_NORMAL, `LNMW_CM_RXONLY, 2'h0, 4'hb, 2'h1, 2'h2},
      '{`LNMW_SM_NORMAL, `LNMW_CM_NORMAL, `LNMW_CM_NORMAL, 2'h1, 4'hf, 2'h2, 2'h1},
      '{`LNMW_SM_NORMAL, `LNMW_CM_OFF, `LNMW_CM_OFF, 2'h0, 4'h0, 2'h0, 2'h3},
      '{`LNMW_SM_FAILSAFE, `LNMW_CM_NORMAL, `LNMW_CM_NORMAL, 2'h0, 4'h5, 2'h0, 2'h3}};
   // small timer values keep the run short; expectations scale with them
   lnmw_top #(.WAKE_FILT_US(16'h3), .TXD_TO_US(16'h14), .BUS_TO_US(16'h14), .EN_TIME_US(16'h2)) DUT (
      .REF_CLK(ref_clk), .RST_B(rst_b), .SYS_MODE(sm), .FIRST_CHANNEL_MODE_BITS(m0),
      .SECOND_CHANNEL_MODE_BITS(m1), .WATCHDOG_ON_BUS_WAKE(wd_opt), .WATCHDOG_ENABLED(wd_on),
      .LOW_SLOPE_SELECT_WR(lsw), .SPI_CS_B(cs_b), .BUS_SUPPLY_UV(uv), .FAULT_CLR(fclr), .INT_ACK(ack),
      .TRANSMIT_INPUT(txd), .RECEIVE_OUTPUT_PIN(rx), .BUS_I(bus_i), .BUS_O(bus_o), .BUS_OE(oe),
      .CH_MODE_RB(rb), .FIRST_CHANNEL_FAULT_FLAG(f0), .SECOND_CHANNEL_FAULT_FLAG(f1), .LOW_SLOPE(slope),
      .INT_B(int_b), .WD_AUTO_EN(wd_en), .RESTART_REQ(rst_req), .WAKE_SRC_VALID(vld), .WAKE_SRC(src),
      .WAKE_SRC_READY(rdy));
   lnmw_bus_node u_node (.bus_oe(oe), .node_dom(node_dom), .bus_i(bus_i));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   initial begin
      forever #10 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (rst_req === 1'b1) restart_n++;
      if (wd_en === 1'b1) wd_n++;
      if (cycles == 20000) begin
         bad_count++;
         $display("CHECK FAILED at %0t: run too long", $time);
         end_sim();
      end
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask
   // another node holds the bus dominant, then releases it
   task automatic dom(input logic [1:0] m, input int us);
      node_dom = m;
      cyc(us * US);
      node_dom = 2'h0;
      cyc(10);
   endtask
   task automatic pulse_ack;
      ack = 1'b1;
      cyc(1);
      ack = 1'b0;
      cyc(1);
   endtask
   task automatic pop;
      rdy = 1'b1;
      cyc(1);
      rdy = 1'b0;
      cyc(2);
   endtask
   task automatic cs_write;
      cs_b = 1'b0;
      cyc(8);
      cs_b = 1'b1;
      cyc(8);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      cyc(8);
      rst_b = 1'b1;
      cyc(4);
      check({rb, oe, rx}, 8'h03);
      check({3'h0, bus_o, int_b, slope, f0}, 8'h04);
      $display("reset test done");
      foreach (rows[i]) begin
         {sm, m0, m1} = {rows[i].sm, rows[i].m0, rows[i].m1};
         txd = 2'h3;
         cyc(200);
         txd = rows[i].txd;
         cyc(6);
         check({rb, oe, rx}, {rows[i].rb, rows[i].oe, rows[i].rx});
      end
      $display("table test done");
      // dominant present before enabling ends is not sent
      {sm, m0, m1} = {`LNMW_SM_NORMAL, `LNMW_CM_OFF, `LNMW_CM_OFF};
      txd = 2'h2;
      cyc(20);
      m0 = `LNMW_CM_NORMAL;
      cyc(200);
      check({6'h0, oe}, 8'h00);
      txd = 2'h3;
      cyc(4);
      txd = 2'h2;
      cyc(6);
      check({6'h0, oe}, 8'h01);
      cyc(25 * US);
      check({oe, rb, 1'b0, f0}, 8'h0d);
      txd = 2'h3;
      cyc(6);
      txd = 2'h2;
      cyc(6);
      check({6'h0, oe}, 8'h01);
      txd = 2'h3;
      fclr = 2'h1;
      cyc(1);
      fclr = 2'h0;
      cyc(2);
      check({7'h0, f0}, 8'h00);
      m1 = `LNMW_CM_RXONLY;
      dom(2'h2, 25);
      check({3'h0, rb, f1}, 8'h17);
      txd = 2'h2;
      cyc(6);
      uv = 1'b1;
      cyc(8);
      check({rx, oe, rb}, 8'hcb);
      uv = 1'b0;
      txd = 2'h3;
      $display("transmit test done");
      // wakes on both channels fill the two-entry record buffer
      {m0, m1} = {`LNMW_CM_WAKE, `LNMW_CM_WAKE};
      cyc(20);
      dom(2'h3, 2);
      check({rx, int_b, vld}, 8'h0e);
      dom(2'h3, 6);
      check({rx, int_b, vld, rb}, 8'h15);
      check({4'h0, src}, 8'h00);
      pop();
      check({3'h0, vld, src}, 8'h18);
      pop();
      dom(2'h3, 6);
      check({7'h0, vld}, 8'h00);
      pulse_ack();
      check({7'h0, int_b}, 8'h01);
      m0 = `LNMW_CM_OFF;
      cyc(6);
      check({6'h0, rx}, 8'h01);
      dom(2'h1, 6);
      check({4'h0, int_b, vld, rx}, 8'h09);
      m0 = `LNMW_CM_WAKE;
      cyc(6);
      dom(2'h1, 6);
      check({3'h0, vld, src}, 8'h10);
      pop();
      pulse_ack();
      sm = `LNMW_SM_SLEEP;
      cyc(6);
      restart_n = 0;
      dom(2'h2, 6);
      check({3'h0, vld, src}, 8'h1a);
      check({7'h0, int_b}, 8'h01);
      check(restart_n[7:0], 8'h01);
      pop();
      {wd_opt, sm} = {1'b1, `LNMW_SM_STOP};
      cyc(6);
      dom(2'h1, 6);
      check({wd_n[6:0], int_b}, 8'h02);
      pop();
      pulse_ack();
      sm = `LNMW_SM_FAILSAFE;
      cyc(6);
      restart_n = 0;
      dom(2'h1, 6);
      check({restart_n[6:0], int_b}, 8'h03);
      pop();
      $display("wake test done");
      // slope bit accepted only in system normal
      lsw = 1'b1;
      sm = `LNMW_SM_STOP;
      cs_write();
      check({7'h0, slope}, 8'h00);
      sm = `LNMW_SM_NORMAL;
      cs_write();
      check({7'h0, slope}, 8'h01);
      $display("slope test done");
      end_sim();
   end
endmodule
`default_nettype wire
